// ==== logic/rivm_pkg.sv ====
// Package: vector addresses, sources and timing for the vector map
package rivm_pkg;
	localparam int ADDR_W     = 16;
	localparam int SRC_N      = 24;
	localparam int SRC_W      = 5;
	localparam int CHANGE_WIN = 4;
	localparam logic [ADDR_W-1:0] RESET_VEC     = 16'h0000;
	localparam logic [ADDR_W-1:0] TABLE_OFFSET  = 16'h0002;
	localparam logic [ADDR_W-1:0] BOOT_RESET_DF = 16'h3800;
	localparam logic              FUSE_PROGRAMMED = 1'b0;
	localparam logic              VSEL_RESET    = 1'b0;
	// Source indices, in priority order (lowest index wins)
	localparam int SRC_EXT0    = 0;
	localparam int SRC_PCG0    = 1;
	localparam int SRC_PCG1    = 2;
	localparam int SRC_T2_CMP  = 3;
	localparam int SRC_T2_OVF  = 4;
	localparam int SRC_T1_CAP  = 5;
	localparam int SRC_T1_CMPA = 6;
	localparam int SRC_T1_CMPB = 7;
	localparam int SRC_T1_OVF  = 8;
	localparam int SRC_T0_CMP  = 9;
	localparam int SRC_T0_OVF  = 10;
	localparam int SRC_SPI     = 11;
	localparam int SRC_RXC     = 12;
	localparam int SRC_TXE     = 13;
	localparam int SRC_TXC     = 14;
	localparam int SRC_USI_ST  = 15;
	localparam int SRC_USI_OV  = 16;
	localparam int SRC_ACOMP   = 17;
	localparam int SRC_ADC     = 18;
	localparam int SRC_EE      = 19;
	localparam int SRC_SPM     = 20;
	localparam int SRC_LCD     = 21;
	localparam int SRC_PCG2    = 22;
	localparam int SRC_PCG3    = 23;
	typedef logic [ADDR_W-1:0] rivm_addr_t;
	typedef logic [SRC_N-1:0]  rivm_src_t;
	typedef enum logic [1:0] {
		RIVM_IDLE,
		RIVM_ARMED
	} rivm_chg_e;
endpackage

// ==== logic/rivm_sel_if.sv ====
// Interface: pending requests in, winning source out
interface rivm_sel_if;
	import rivm_pkg::*;
	rivm_src_t           pending;
	logic                any;
	logic [SRC_W-1:0]    index;
	modport encoder (input pending, output any, output index);
	modport user    (output pending, input any, input index);
endinterface

// ==== logic/rivm_prio_enc.sv ====
// Priority encoder: lowest pending source index wins
module rivm_prio_enc (
	rivm_sel_if.encoder sel
);
	import rivm_pkg::*;
	logic [SRC_W-1:0] found;
	always_comb begin
		found = '0;
		for (int i = SRC_N - 1; i >= 0; i--) begin
			if (sel.pending[i]) begin
				found = SRC_W'(i);
			end
		end
	end
	assign sel.index = found;
	assign sel.any   = |sel.pending;
endmodule

// ==== logic/rivm_top.sv ====
// Reset and interrupt vector map with boot relocation
module rivm_top #(
	parameter logic LARGE_PKG = 1'b1
) (
	input  wire logic             core_clk,
	input  wire logic             rst_n,
	input  wire logic             boot_reset_fuse,
	input  wire rivm_pkg::rivm_addr_t boot_start,
	input  wire rivm_pkg::rivm_src_t  irq_req,
	input  wire logic             vec_ack,
	input  wire logic             ctrl_wr,
	input  wire logic             wr_vector_table_select,
	input  wire logic             wr_vector_change_enable,
	output logic                  vector_table_select,
	output logic                  vector_change_enable,
	output rivm_pkg::rivm_addr_t  reset_addr,
	output rivm_pkg::rivm_addr_t  vec_addr,
	output logic                  vec_valid,
	output logic [rivm_pkg::SRC_W-1:0] vec_src
);
	import rivm_pkg::*;

	////////////////////////////////////////////////////////////////////////
	// Vector table
	rivm_addr_t vec_tab [SRC_N];
	rivm_src_t  src_present;
	genvar g;
	generate
		for (g = 0; g < SRC_N; g++) begin : g_tab
			assign vec_tab[g] = ADDR_W'(TABLE_OFFSET * (g + 1));
			if (g == SRC_PCG2 || g == SRC_PCG3) begin : g_large
				assign src_present[g] = LARGE_PKG;
			end else begin : g_std
				assign src_present[g] = 1'b1;
			end
		end
	endgenerate
	// Table entries at index*2+2: 0x0008/0x000A
	// 0x000C..0x0012 for timer 1
	// 0x0012 overflow
	// 0x0014/0x0016
	// 0x0018
	// 0x001C
	// 0x001A, 0x001E, 0x0020, 0x0022
	// 0x0024
	// 0x0026
	// 0x002A

	////////////////////////////////////////////////////////////////////////
	// Source selection
	rivm_sel_if sel ();
	assign sel.pending = irq_req & src_present;
	rivm_prio_enc u_enc (
		.sel (sel)
	);

	////////////////////////////////////////////////////////////////////////
	// Base selection
	wire logic       fuse_boot   = (boot_reset_fuse == FUSE_PROGRAMMED);
	wire rivm_addr_t next_reset  = fuse_boot ? boot_start : RESET_VEC;
	wire rivm_addr_t table_base  = vector_table_select ? boot_start : RESET_VEC;
	wire rivm_addr_t next_vec    = ADDR_W'(table_base + vec_tab[sel.index]);

	////////////////////////////////////////////////////////////////////////
	// Timed change of vector-select
	rivm_chg_e         chg_state;
	logic [2:0]        chg_cnt;
	wire logic         arm_write  = ctrl_wr & wr_vector_change_enable;
	wire logic         commit     = ctrl_wr & ~wr_vector_change_enable
	                               & (chg_state == RIVM_ARMED);
	wire logic         expire     = (chg_state == RIVM_ARMED)
	                               && (chg_cnt == 3'(CHANGE_WIN - 1));

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			chg_state <= RIVM_IDLE;
			chg_cnt   <= '0;
		end else begin
			case (chg_state)
				RIVM_IDLE: begin
					chg_cnt <= '0;
					if (arm_write) begin
						chg_state <= RIVM_ARMED;
					end
				end
				RIVM_ARMED: begin
					chg_cnt <= chg_cnt + 3'd1;
					if (commit) begin
						chg_state <= RIVM_IDLE;
					end else if (arm_write) begin
						chg_cnt <= '0;
					end else if (expire) begin
						chg_state <= RIVM_IDLE;
					end
				end
				default: chg_state <= RIVM_IDLE;
			endcase
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			vector_table_select  <= VSEL_RESET;
			vector_change_enable <= 1'b0;
		end else begin
			if (commit) begin
				vector_table_select <= wr_vector_table_select;
			end
			vector_change_enable <= arm_write
			                        | (vector_change_enable & ~commit & ~expire);
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Outputs toward the core
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			reset_addr <= RESET_VEC;
			vec_addr   <= RESET_VEC;
			vec_valid  <= 1'b0;
			vec_src    <= '0;
		end else begin
			reset_addr <= next_reset;
			vec_addr   <= next_vec;
			vec_valid  <= sel.any & ~vec_ack;
			vec_src    <= sel.index;
		end
	end
endmodule

// ==== dv/rivm_core_model.sv ====
// Core model: takes each offered vector, at once or not at all while held
module rivm_core_model (
	input  wire logic core_clk,
	input  wire logic hold,
	input  wire logic vec_valid,
	output logic      vec_ack
);
	timeunit 1ns;
	timeprecision 1ns;
	always_ff @(posedge core_clk)
		vec_ack <= vec_valid && !vec_ack && !hold;
endmodule

// ==== dv/rivm_chk.sv ====
// Checker: port-level properties of the vector map
module rivm_chk #(
	parameter logic LARGE_PKG = 1'b1
) (
	input wire logic        core_clk,
	input wire logic        rst_n,
	input wire logic        boot_reset_fuse,
	input wire logic [15:0] boot_start,
	input wire logic [23:0] irq_req,
	input wire logic        vec_ack,
	input wire logic        ctrl_wr,
	input wire logic        wr_vector_table_select,
	input wire logic        wr_vector_change_enable,
	input wire logic        vector_table_select,
	input wire logic        vector_change_enable,
	input wire logic [15:0] reset_addr,
	input wire logic [15:0] vec_addr,
	input wire logic        vec_valid,
	input wire logic [4:0]  vec_src
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_n);
	wire logic cmt = ctrl_wr && vector_change_enable && !wr_vector_change_enable;
	wire logic [23:0] msk = irq_req & {LARGE_PKG, LARGE_PKG, 22'h3F_FFFF};
	property p_rst; $past(rst_n) |-> reset_addr == ($past(boot_reset_fuse) ? 16'h0000
		: $past(boot_start)); endproperty
	a_rst: assert property (p_rst) else $error("reset address wrong");
	property p_vld; $past(rst_n) |-> vec_valid == (|$past(msk) && !$past(vec_ack)); endproperty
	a_vld: assert property (p_vld) else $error("vector valid wrong");
	property p_src; vec_valid |-> (($past(msk) >> vec_src) & 24'h00_0001) == 24'h00_0001
		&& ($past(msk) & ((24'h00_0001 << vec_src) - 24'h00_0001)) == 24'h00_0000; endproperty
	a_src: assert property (p_src) else $error("winning source wrong");
	property p_adr; vec_valid |-> vec_addr == ($past(vector_table_select) ? $past(boot_start)
		: 16'h0000) + 16'(2 * vec_src + 2); endproperty
	a_adr: assert property (p_adr) else $error("vector address wrong");
	property p_arm; ctrl_wr && wr_vector_change_enable |=> vector_change_enable; endproperty
	a_arm: assert property (p_arm) else $error("change enable not set");
	property p_exp; $rose(vector_change_enable) ##0 !ctrl_wr [*4] |=> !vector_change_enable;
	endproperty
	a_exp: assert property (p_exp) else $error("change enable not expired");
	property p_cmt; cmt |=> vector_table_select == $past(wr_vector_table_select)
		&& !vector_change_enable; endproperty
	a_cmt: assert property (p_cmt) else $error("select not committed");
	property p_hld; !cmt |=> $stable(vector_table_select); endproperty
	a_hld: assert property (p_hld) else $error("select changed unarmed");
endmodule
bind rivm_top rivm_chk #(.LARGE_PKG(LARGE_PKG)) u_chk (.*);

// ==== dv/reset_interrupt_vector_map_bench.sv ====
// Testbench: vector map, relocation and change window scenarios
module reset_interrupt_vector_map_bench;
	timeunit 1ns;
	timeprecision 1ns;
	import rivm_pkg::*;
	logic       core_clk = 0;
	logic       rst_n = 0;
	logic       boot_reset_fuse = 1;
	logic       ctrl_wr = 0;
	logic       wr_vector_table_select = 0;
	logic       wr_vector_change_enable = 0;
	logic       hold = 0;
	logic       vec_ack, vec_valid, vector_table_select, vector_change_enable;
	rivm_addr_t boot_start = 16'h3800;
	rivm_addr_t reset_addr, vec_addr;
	rivm_src_t  irq_req = '0;
	logic [4:0] vec_src;
	int         mismatches = 0;
	int         cmp_count = 0;
	always #5 core_clk = ~core_clk;
	rivm_top DUT (.*);
	rivm_core_model u_core (.core_clk, .hold, .vec_valid, .vec_ack);
	task cmp(input rivm_addr_t a, e);
		cmp_count++;
		if (a !== e) begin
			mismatches++;
			$display("unexpected at %0t: %h vs %h", $time, a, e);
		end
	endtask
	task test_done;
		$display("mismatches %0d compares %0d", mismatches, cmp_count);
		if (mismatches == 0 && cmp_count > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	task wr(input logic ce, sel);
		@(posedge core_clk);
		ctrl_wr <= 1;
		wr_vector_change_enable <= ce;
		wr_vector_table_select <= sel;
		@(posedge core_clk);
		ctrl_wr <= 0;
	endtask
	task rearm;
		wr(1'b1, 1'b1);
		repeat (2) @(posedge core_clk);
		wr(1'b1, 1'b1);
		#1 cmp(16'(vector_change_enable), 16'h0001);
		repeat (2) @(posedge core_clk);
		wr(1'b0, 1'b0);
		#1 cmp(16'(vector_table_select), 16'h0000);
	endtask
	task rchk(input logic f, input rivm_addr_t e);
		@(posedge core_clk);
		boot_reset_fuse <= f;
		repeat (2) @(posedge core_clk);
		#1 cmp(reset_addr, e);
	endtask
	task vec(input rivm_addr_t base, input logic slow);
		int n;
		for (int i = 0; i < SRC_N; i++) begin
			@(posedge core_clk);
			irq_req <= (24'h1 << i) | 24'h80_0000;
			hold <= slow;
			n = 0;
			do begin
				@(posedge core_clk);
				#1 n++;
			end while (vec_valid !== 1'b1 && n < 4);
			if (vec_valid !== 1'b1) begin
				mismatches++;
				test_done;
			end
			cmp(vec_addr, base + 16'(2 * i + 2));
			cmp(16'(vec_src), 16'(i));
		end
	endtask
	initial begin
		repeat (10) @(posedge core_clk);
		rst_n <= 1;
		rchk(1'b1, 16'h0000);
		rchk(1'b0, 16'h3800);
		vec(16'h0000, 1'b0);
		wr(1'b1, 1'b0);
		#1 cmp(16'(vector_change_enable), 16'h0001);
		repeat (2) @(posedge core_clk);
		wr(1'b0, 1'b1);
		#1 cmp(16'(vector_table_select), 16'h0001);
		cmp(16'(vector_change_enable), 16'h0000);
		wr(1'b1, 1'b1);
		repeat (3) @(posedge core_clk);
		wr(1'b0, 1'b0);
		#1 cmp(16'(vector_table_select), 16'h0001);
		cmp(16'(vector_change_enable), 16'h0000);
		vec(16'h3800, 1'b1);
		rearm;
		test_done;
	end
endmodule
